// >>> logic/dpram_pkg.sv
// Notes on behaviour
// - Synchronous ports, each up to 350 MHz
// - Organisations 4kx1, 2kx2, 1kx4, 512x9 dual-port
// - Plain mode takes addresses from user logic
// - Queue mode: internal addresses plus four flags
// - Width select 00/01/10/11 picks x1/x2/x4/x9
// - Each port chooses its width independently
// - Narrow widths leave ninth bit unused
// - Ninth bit undefined after narrow write
// - Narrow lanes packed little-endian in words
// - Active-low block select; disabled output holds
// - In plain mode, write select low writes, high reads
// - Pipeline select adds one cycle of latency
// - Write-output mode: retain or pass written data
// - Reset zeroes outputs except hreadyout_o (held high), blocks access, keeps contents
// - Read bits above width may be anything
// - Both ports run on one shared clock, core_clk_i
// - Inputs sampled on rising clock edge only, except rst_b_i, which acts asynchronously
package dpram_pkg;
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 9;
    localparam int WORDS    = 512;
    localparam int WORD_AW  = 9;
    localparam int FILL_W   = 13;
    localparam int HADDR_W  = 8;
    localparam int CFG_BITS = 9;

    localparam logic [1:0] WIDTH_X1 = 2'h0;
    localparam logic [1:0] WIDTH_X2 = 2'h1;
    localparam logic [1:0] WIDTH_X4 = 2'h2;
    localparam logic [1:0] WIDTH_X9 = 2'h3;

    localparam logic [DATA_W-1:0] MASK_X1 = 9'h001;
    localparam logic [DATA_W-1:0] MASK_X2 = 9'h003;
    localparam logic [DATA_W-1:0] MASK_X4 = 9'h00f;
    localparam logic [DATA_W-1:0] MASK_X9 = 9'h1ff;

    localparam logic [FILL_W-1:0] DEPTH_X1 = 13'h1000;
    localparam logic [FILL_W-1:0] DEPTH_X2 = 13'h0800;
    localparam logic [FILL_W-1:0] DEPTH_X4 = 13'h0400;
    localparam logic [FILL_W-1:0] DEPTH_X9 = 13'h0200;

    // Register map
    localparam logic [HADDR_W-1:0]  CONFIG_OFFSET = 8'h00;
    localparam logic [HADDR_W-1:0]  STATUS_OFFSET = 8'h04;
    localparam logic [CFG_BITS-1:0] CFG_RESET     = 9'h000;
    localparam int CFG_WIDTH_LSB  = 0;
    localparam int CFG_PIPE_LSB   = 4;
    localparam int CFG_WMODE_LSB  = 6;
    localparam int CFG_QUEUE      = 8;
    localparam int STAT_FULL      = 0;
    localparam int STAT_EMPTY     = 1;
    localparam int STAT_ALMOST_FULL  = 2;
    localparam int STAT_ALMOST_EMPTY = 3;
    localparam int STAT_FILL_LSB  = 16;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] w);
        case (w)
            WIDTH_X1: lane_mask = MASK_X1;
            WIDTH_X2: lane_mask = MASK_X2;
            WIDTH_X4: lane_mask = MASK_X4;
            default:  lane_mask = MASK_X9;
        endcase
    endfunction

    // Lowest address bits pick the lane, lane 0 in the low bits
    function automatic logic [3:0] lane_shift(input logic [1:0] w, input logic [ADDR_W-1:0] a);
        case (w)
            WIDTH_X1: lane_shift = {1'b0, a[2:0]};
            WIDTH_X2: lane_shift = {1'b0, a[1:0], 1'b0};
            WIDTH_X4: lane_shift = {1'b0, a[0], 2'h0};
            default:  lane_shift = 4'h0;
        endcase
    endfunction

    function automatic logic [WORD_AW-1:0] word_index(input logic [1:0] w, input logic [ADDR_W-1:0] a);
        case (w)
            WIDTH_X1: word_index = a[11:3];
            WIDTH_X2: word_index = a[10:2];
            WIDTH_X4: word_index = a[9:1];
            default:  word_index = a[8:0];
        endcase
    endfunction

    function automatic logic [FILL_W-1:0] queue_depth(input logic [1:0] w);
        case (w)
            WIDTH_X1: queue_depth = DEPTH_X1;
            WIDTH_X2: queue_depth = DEPTH_X2;
            WIDTH_X4: queue_depth = DEPTH_X4;
            default:  queue_depth = DEPTH_X9;
        endcase
    endfunction
endpackage

// >>> logic/port_lane_if.sv
`timescale 1ns/1ps
`default_nettype none

interface port_lane_if;
    logic [1:0]                        width_sel;
    logic [dpram_pkg::ADDR_W-1:0]      address;
    logic [dpram_pkg::DATA_W-1:0]      write_data;
    logic [dpram_pkg::DATA_W-1:0]      stored_word;
    logic [dpram_pkg::WORD_AW-1:0]     word_index;
    logic [dpram_pkg::DATA_W-1:0]      lane_mask;
    logic [dpram_pkg::DATA_W-1:0]      lane_data;
    logic [dpram_pkg::DATA_W-1:0]      read_value;
    logic                              access;
    logic                              is_write;
    logic                              pipe;
    logic                              wmode;
    logic [dpram_pkg::DATA_W-1:0]      read_data;

    modport mapper (input width_sel, address, write_data, stored_word,
                    output word_index, lane_mask, lane_data, read_value);
    modport stage  (input access, is_write, pipe, wmode, read_value, write_data,
                    output read_data);
endinterface

`default_nettype wire

// >>> logic/lane_mapper.sv
`timescale 1ns/1ps
`default_nettype none

module lane_mapper (
    port_lane_if.mapper port
);
    import dpram_pkg::*;

    logic [3:0]        shift;
    logic [DATA_W-1:0] mask;

    always_comb begin
        shift           = lane_shift(port.width_sel, port.address);
        mask            = lane_mask(port.width_sel);
        port.word_index = word_index(port.width_sel, port.address);
        port.lane_mask  = DATA_W'(mask << shift);
        port.lane_data  = DATA_W'((port.write_data & mask) << shift);
        // Bits above the width read as zero, bit 8 included in the narrow widths
        port.read_value = DATA_W'((port.stored_word >> shift) & mask);
    end
endmodule

`default_nettype wire

// >>> logic/read_stage.sv
`timescale 1ns/1ps
`default_nettype none

module read_stage (
    input  wire logic   core_clk_i,
    input  wire logic   rst_b_i,
    port_lane_if.stage  port
);
    import dpram_pkg::*;

    logic [DATA_W-1:0] stage_word;
    logic [DATA_W-1:0] next_word;
    logic              load;

    always_comb begin
        // A read always loads; a write loads only in pass-through mode
        load      = port.access && (!port.is_write || port.wmode);
        next_word = port.is_write ? port.write_data : port.read_value;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stage_word <= '0;
        end else if (load) begin
            stage_word <= next_word;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            port.read_data <= '0;
        end else if (port.pipe) begin
            port.read_data <= stage_word;
        end else if (load) begin
            port.read_data <= next_word;
        end
    end
endmodule

`default_nettype wire

// >>> logic/dual_port_block_sram.sv
`timescale 1ns/1ps
`default_nettype none

module dual_port_block_sram #(
    parameter logic [12:0] ALMOST_FULL_GAP  = 13'h004,
    parameter logic [12:0] ALMOST_EMPTY_LVL = 13'h004
) (
    input  wire logic                          core_clk_i,
    input  wire logic                          rst_b_i,
    input  wire logic                          hsel_i,
    input  wire logic [31:0]                   haddr_i,
    input  wire logic [1:0]                    htrans_i,
    input  wire logic                          hwrite_i,
    input  wire logic [2:0]                    hsize_i,
    input  wire logic [31:0]                   hwdata_i,
    input  wire logic                          hready_i,
    output logic      [31:0]                   hrdata_o,
    output logic                               hreadyout_o,
    output logic                               hresp_o,
    input  wire logic                          port_a_block_select_n_i,
    input  wire logic                          port_a_write_select_n_i,
    input  wire logic [dpram_pkg::ADDR_W-1:0]  port_a_address_i,
    input  wire logic [dpram_pkg::DATA_W-1:0]  port_a_write_data_i,
    output logic      [dpram_pkg::DATA_W-1:0]  port_a_read_data_o,
    input  wire logic                          port_b_block_select_n_i,
    input  wire logic                          port_b_write_select_n_i,
    input  wire logic [dpram_pkg::ADDR_W-1:0]  port_b_address_i,
    input  wire logic [dpram_pkg::DATA_W-1:0]  port_b_write_data_i,
    output logic      [dpram_pkg::DATA_W-1:0]  port_b_read_data_o,
    output logic                               full_flag_o,
    output logic                               empty_flag_o,
    output logic                               almost_full_flag_o,
    output logic                               almost_empty_flag_o
);
    import dpram_pkg::*;

    // ==========================================================
    // Declarations
    logic                         ph_valid;
    logic                         ph_write;
    logic [HADDR_W-1:0]           ph_addr;
    logic [CFG_BITS-1:0]          cfg;
    logic [CFG_BITS-1:0]          next_cfg;
    logic [31:0]                  status_word;
    logic                         addr_phase;
    logic                         queue_on;
    logic [1:0]                   blocked;
    logic [1:0]                   sel_n;
    logic [1:0]                   we_n;
    logic [1:0][ADDR_W-1:0]       addr_in;
    logic [1:0][DATA_W-1:0]       wdat_in;
    logic [1:0]                   access;
    logic [1:0]                   is_write;
    logic [1:0]                   wr_en;
    logic [1:0][DATA_W-1:0]       merged;
    logic [DATA_W-1:0]            base_b;
    logic [DATA_W-1:0]            mem [WORDS];
    logic [ADDR_W-1:0]            wr_ptr;
    logic [ADDR_W-1:0]            rd_ptr;
    logic [FILL_W-1:0]            fill;
    logic [FILL_W-1:0]            next_fill;
    logic [FILL_W-1:0]            depth;
    logic                         push;
    logic                         pop;

    port_lane_if lane [2] ();

    // ==========================================================
    // Register bus slave
    assign addr_phase = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && hsize_i == HSIZE_WORD;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr  <= '0;
        end else if (hready_i) begin
            ph_valid <= addr_phase;
            ph_write <= hwrite_i;
            ph_addr  <= haddr_i[HADDR_W-1:0];
        end
    end

    always_comb begin
        next_cfg = cfg;
        if (ph_valid && ph_write && ph_addr == CONFIG_OFFSET) begin
            next_cfg = hwdata_i[CFG_BITS-1:0];
        end
    end

    // Width selects live here and are expected to stay put while ports run
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg <= CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    always_comb begin
        status_word = '0;
        status_word[STAT_FULL] = full_flag_o;
        status_word[STAT_EMPTY] = empty_flag_o;
        status_word[STAT_ALMOST_FULL] = almost_full_flag_o;
        status_word[STAT_ALMOST_EMPTY] = almost_empty_flag_o;
        status_word[STAT_FILL_LSB +: FILL_W] = fill;
    end

    // Read data is latched in the address phase; next_cfg forwards a write still in its data phase
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hrdata_o <= '0;
        end else if (addr_phase && !hwrite_i) begin
            if (haddr_i[HADDR_W-1:0] == CONFIG_OFFSET) begin
                hrdata_o <= {{(32 - CFG_BITS){1'b0}}, next_cfg};
            end else if (haddr_i[HADDR_W-1:0] == STATUS_OFFSET) begin
                hrdata_o <= status_word;
            end else begin
                hrdata_o <= '0;
            end
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= HRESP_OKAY;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= HRESP_OKAY;
        end
    end

    // ==========================================================
    // Ports
    assign queue_on = cfg[CFG_QUEUE];
    assign sel_n    = {port_b_block_select_n_i, port_a_block_select_n_i};
    assign we_n     = {port_b_write_select_n_i, port_a_write_select_n_i};
    assign addr_in  = {port_b_address_i, port_a_address_i};
    assign wdat_in  = {port_b_write_data_i, port_a_write_data_i};
    assign blocked  = {empty_flag_o, full_flag_o} & {2{queue_on}};

    // Both ports share core_clk_i; each keeps its own select, width and mode
    for (genvar p = 0; p < 2; p++) begin : g_port
        assign access[p]   = rst_b_i && !sel_n[p] && !blocked[p];
        // In queue mode port A only fills and port B only drains
        assign is_write[p] = queue_on ? (p == 0) : !we_n[p];
        assign wr_en[p]    = access[p] && is_write[p];

        assign lane[p].width_sel  = cfg[CFG_WIDTH_LSB + 2 * p +: 2];
        assign lane[p].address    = queue_on ? ((p == 0) ? wr_ptr : rd_ptr) : addr_in[p];
        assign lane[p].write_data = wdat_in[p];
        assign lane[p].stored_word = mem[lane[p].word_index];
        assign lane[p].access     = access[p];
        assign lane[p].is_write   = is_write[p];
        assign lane[p].pipe       = cfg[CFG_PIPE_LSB + p];
        assign lane[p].wmode      = cfg[CFG_WMODE_LSB + p];

        lane_mapper u_mapper (
            .port (lane[p])
        );

        read_stage u_stage (
            .core_clk_i (core_clk_i),
            .rst_b_i    (rst_b_i),
            .port       (lane[p])
        );
    end

    assign port_a_read_data_o = lane[0].read_data;
    assign port_b_read_data_o = lane[1].read_data;

    // ==========================================================
    // Storage
    // Same-word writes from both ports merge; port B wins on overlapping bits
    always_comb begin
        merged[0] = (lane[0].stored_word & ~lane[0].lane_mask) | lane[0].lane_data;
        base_b    = (wr_en[0] && lane[0].word_index == lane[1].word_index) ? merged[0] : lane[1].stored_word;
        merged[1] = (base_b & ~lane[1].lane_mask) | lane[1].lane_data;
    end

    // No reset: contents survive reset
    always_ff @(posedge core_clk_i) begin
        if (wr_en[0]) begin
            mem[lane[0].word_index] <= merged[0];
        end
        if (wr_en[1]) begin
            mem[lane[1].word_index] <= merged[1];
        end
    end

    // ==========================================================
    // Queue controller
    // Depth follows port A's width; both widths should match in queue mode
    assign depth = queue_depth(lane[0].width_sel);
    assign push  = queue_on && wr_en[0];
    assign pop   = queue_on && access[1];
    assign next_fill = FILL_W'(fill + {{(FILL_W - 1){1'b0}}, push} - {{(FILL_W - 1){1'b0}}, pop});

    function automatic logic [ADDR_W-1:0] ptr_step(input logic [ADDR_W-1:0] ptr, input logic [FILL_W-1:0] d);
        logic [FILL_W-1:0] wide;
        wide     = ({1'b0, ptr} + 13'h0001) & (d - 13'h0001);
        ptr_step = wide[ADDR_W-1:0];
    endfunction

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else if (!queue_on) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (push) begin
                wr_ptr <= ptr_step(wr_ptr, depth);
            end
            if (pop) begin
                rd_ptr <= ptr_step(rd_ptr, depth);
            end
            fill <= next_fill;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            full_flag_o         <= 1'b0;
            empty_flag_o        <= 1'b0;
            almost_full_flag_o  <= 1'b0;
            almost_empty_flag_o <= 1'b0;
        end else begin
            full_flag_o         <= (queue_on ? next_fill : '0) == depth;
            empty_flag_o        <= (queue_on ? next_fill : '0) == '0;
            almost_full_flag_o  <= (queue_on ? next_fill : '0) >= depth - ALMOST_FULL_GAP;
            almost_empty_flag_o <= (queue_on ? next_fill : '0) <= ALMOST_EMPTY_LVL;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_reset_out_zero: assert property (
        !$past(rst_b_i) |-> port_a_read_data_o == '0 && port_b_read_data_o == '0)
        else $error("read data not zero after reset");

    a_flow_read_data: assert property (
        (access[0] && !is_write[0] && !lane[0].pipe) |=> port_a_read_data_o == $past(lane[0].read_value))
        else $error("flow-through read data wrong");

    a_pipe_read_data: assert property (
        (access[0] && !is_write[0] && lane[0].pipe) ##1 lane[0].pipe
        |=> port_a_read_data_o == $past(lane[0].read_value, 2))
        else $error("pipelined read data wrong");

    a_hold_when_off: assert property (
        (sel_n[0] && !lane[0].pipe) |=> $stable(port_a_read_data_o))
        else $error("disabled port output changed");

    a_write_retain: assert property (
        (wr_en[0] && !lane[0].wmode && !lane[0].pipe) |=> $stable(port_a_read_data_o))
        else $error("output changed on retaining write");

    a_write_pass: assert property (
        (wr_en[0] && lane[0].wmode && !lane[0].pipe) |=> port_a_read_data_o == $past(port_a_write_data_i))
        else $error("write data not passed to output");

    a_word_stored: assert property (
        (wr_en[0] && !wr_en[1]) |=> mem[$past(lane[0].word_index)] == $past(merged[0]))
        else $error("port A write not stored");

    a_plain_address: assert property (
        !queue_on |-> lane[1].address == port_b_address_i)
        else $error("plain mode address not from user");

    a_queue_address: assert property (
        (queue_on && $past(queue_on) && $past(push)) |-> lane[0].address == ptr_step($past(wr_ptr), depth))
        else $error("queue write pointer did not advance");

    a_empty_flag: assert property (
        $past(rst_b_i) |-> empty_flag_o == (fill == '0))
        else $error("empty flag disagrees with fill");

    a_full_blocks: assert property (
        (queue_on && full_flag_o) |-> !wr_en[0])
        else $error("write accepted while full");

    a_cfg_write: assert property (
        (ph_valid && ph_write && ph_addr == CONFIG_OFFSET) |=> cfg == $past(hwdata_i[CFG_BITS-1:0]))
        else $error("config register not written");

    a_b_flow_read: assert property (
        (access[1] && !is_write[1] && !lane[1].pipe) |=> port_b_read_data_o == $past(lane[1].read_value))
        else $error("port B flow-through read data wrong");

    a_b_pipe_read: assert property (
        (access[1] && !is_write[1] && lane[1].pipe) ##1 lane[1].pipe
        |=> port_b_read_data_o == $past(lane[1].read_value, 2))
        else $error("port B pipelined read data wrong");

    a_b_hold_off: assert property (
        (sel_n[1] && !lane[1].pipe) |=> $stable(port_b_read_data_o))
        else $error("disabled port B output changed");

    a_b_write_retain: assert property (
        (wr_en[1] && !lane[1].wmode && !lane[1].pipe) |=> $stable(port_b_read_data_o))
        else $error("port B output changed on retaining write");

    a_b_write_pass: assert property (
        (wr_en[1] && lane[1].wmode && !lane[1].pipe) |=> port_b_read_data_o == $past(port_b_write_data_i))
        else $error("port B write data not passed to output");

    a_b_word_stored: assert property (
        wr_en[1] |=> mem[$past(lane[1].word_index)] == $past(merged[1]))
        else $error("port B write not stored");

    a_empty_blocks: assert property (
        (queue_on && empty_flag_o) |-> !access[1])
        else $error("read accepted while empty");

    a_plain_addr_a: assert property (
        !queue_on |-> lane[0].address == port_a_address_i)
        else $error("plain mode port A address not from user");

    a_queue_read_addr: assert property (
        (queue_on && $past(queue_on) && $past(pop)) |-> lane[1].address == ptr_step($past(rd_ptr), depth))
        else $error("queue read pointer did not advance");

    a_almost_empty: assert property (
        $past(rst_b_i) |-> almost_empty_flag_o == (fill <= ALMOST_EMPTY_LVL))
        else $error("almost empty flag disagrees with fill");

    c_pipe_read:  cover property (access[0] && !is_write[0] && lane[0].pipe ##2 lane[0].pipe);
    c_write_pass: cover property (wr_en[0] && lane[0].wmode);
    c_queue_full: cover property (queue_on && full_flag_o);
    c_same_word:  cover property (wr_en[0] && wr_en[1] && lane[0].word_index == lane[1].word_index);

endmodule

`default_nettype wire

// >>> bench/fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Fabric logic on both ports
module fabric_model (
    input  wire logic        core_clk_i,
    output logic [1:0]       sel_n_o,
    output logic [1:0]       we_n_o,
    output logic [1:0][11:0] addr_o,
    output logic [1:0][8:0]  data_o
);
    initial begin
        sel_n_o = 2'h3;
        we_n_o  = 2'h3;
        addr_o  = '0;
        data_o  = '0;
    end
    // One access; released after the taking edge, data inverted so a stale value never looks valid
    task automatic go(input int p, input logic s, input logic w, input logic [11:0] a, input logic [8:0] d);
        @(posedge core_clk_i);
        sel_n_o[p] <= s;
        we_n_o[p]  <= w;
        addr_o[p]  <= a;
        data_o[p]  <= d;
        @(posedge core_clk_i);
        sel_n_o[p] <= 1'b1;
        data_o[p]  <= ~d;
    endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench top
module testbench;
    import dpram_pkg::*;
    logic             core_clk_i = 0;
    logic             rst_b_i    = 0;
    logic             hsel       = 0;
    logic             hwrite     = 0;
    logic [1:0]       htrans     = 0;
    logic [31:0]      haddr      = 0;
    logic [31:0]      hwdata     = 0;
    logic [31:0]      hrdata;
    logic [31:0]      r;
    logic             ready;
    logic             hresp;
    logic [1:0]       sel_n;
    logic [1:0]       we_n;
    logic [1:0][11:0] addr;
    logic [1:0][8:0]  wd;
    logic [1:0][8:0]  rd;
    logic [3:0]       fl;
    int               miscompares = 0;
    int               check_count = 0;
    int               cyc = 0;

    always #5 core_clk_i = ~core_clk_i;

    fabric_model fab (.core_clk_i(core_clk_i), .sel_n_o(sel_n), .we_n_o(we_n), .addr_o(addr), .data_o(wd));

    dual_port_block_sram DUT (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(HSIZE_WORD), .hwdata_i(hwdata), .hready_i(ready), .hrdata_o(hrdata),
        .hreadyout_o(ready), .hresp_o(hresp), .port_a_block_select_n_i(sel_n[0]),
        .port_a_write_select_n_i(we_n[0]), .port_a_address_i(addr[0]), .port_a_write_data_i(wd[0]),
        .port_a_read_data_o(rd[0]), .port_b_block_select_n_i(sel_n[1]), .port_b_write_select_n_i(we_n[1]),
        .port_b_address_i(addr[1]), .port_b_write_data_i(wd[1]), .port_b_read_data_o(rd[1]),
        .full_flag_o(fl[0]), .empty_flag_o(fl[1]), .almost_full_flag_o(fl[2]), .almost_empty_flag_o(fl[3])
    );

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        @(posedge core_clk_i);
        while (ready !== 1'b1) @(posedge core_clk_i);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk_i);
        while (ready !== 1'b1) @(posedge core_clk_i);
        r = hrdata;
        chk(hresp, HRESP_OKAY);
    endtask

    // Width selects only change while both ports are idle
    task automatic cfg(input logic [31:0] v);
        ahb(1'b1, CONFIG_OFFSET, v);
    endtask

    task automatic t_regs;
        chk(rd, 0);
        ahb(1'b0, STATUS_OFFSET, 0);
        chk(r, 32'h0000000a);
        ahb(1'b0, 32'h08, 0);
        chk(r, 0);
        cfg(32'hffffffff);
        ahb(1'b0, CONFIG_OFFSET, 0);
        chk(r, 32'h000001ff);
        $display("regs done");
    endtask

    task automatic t_lanes;
        int n;
        int lw;
        cfg(32'h0f);
        fab.go(0, 0, 0, 5, 9'h1a5);
        fab.go(1, 0, 1, 5, 0);
        #1 chk(rd[1], 9'h1a5);
        for (int w = 0; w < 3; w++) begin
            cfg(3 | (w << 2));
            fab.go(0, 0, 0, 7, 9'h1b4);
            n  = (w == 0) ? 8 : (w == 1) ? 4 : 2;
            lw = 8 / n;
            for (int k = 0; k < n; k++) begin
                fab.go(1, 0, 1, 12'(7 * n + k), 0);
                #1 chk(rd[1] & ((1 << lw) - 1), (9'h1b4 >> (k * lw)) & ((1 << lw) - 1));
            end
        end
        cfg(32'h0e);
        fab.go(0, 0, 0, 18, 9'h005);
        fab.go(0, 0, 0, 19, 9'h00c);
        fab.go(1, 0, 1, 9, 0);
        #1 chk(rd[1] & 9'h0ff, 9'h0c5);
        $display("lanes done");
    endtask

    task automatic t_pipe_mode;
        cfg(32'h0f);
        fab.go(0, 0, 0, 3, 9'h123);
        cfg(32'h3f);
        fab.go(1, 0, 1, 5, 0);
        @(posedge core_clk_i);
        #1 fab.go(1, 0, 1, 3, 0);
        #1 chk(rd[1], 9'h1a5);
        @(posedge core_clk_i);
        #1 chk(rd[1], 9'h123);
        fab.go(0, 0, 1, 5, 0);
        #1 chk(rd[0], 9'h000);
        @(posedge core_clk_i);
        #1 chk(rd[0], 9'h1a5);
        cfg(32'h0f);
        fab.go(0, 0, 1, 5, 0);
        fab.go(0, 0, 0, 6, 9'h0aa);
        #1 chk(rd[0], 9'h1a5);
        fab.go(1, 0, 0, 6, 9'h0f0);
        #1 chk(rd[1], 9'h123);
        cfg(32'hcf);
        fab.go(0, 0, 0, 6, 9'h155);
        #1 chk(rd[0], 9'h155);
        fab.go(1, 0, 0, 7, 9'h0f0);
        #1 chk(rd[1], 9'h0f0);
        $display("pipe and mode done");
    endtask

    task automatic t_hold;
        cfg(32'h0f);
        fab.go(1, 0, 1, 5, 0);
        fab.go(0, 1, 0, 5, 9'h000);
        fab.go(1, 1, 1, 6, 0);
        #1 chk(rd[1], 9'h1a5);
        @(posedge core_clk_i);
        rst_b_i <= 1'b0;
        fab.go(0, 0, 0, 5, 9'h000);
        #1 chk(rd, 0);
        @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        ahb(1'b0, CONFIG_OFFSET, 0);
        chk(r, 0);
        cfg(32'h0f);
        fab.go(1, 0, 1, 5, 0);
        #1 chk(rd[1], 9'h1a5);
        $display("hold and reset done");
    endtask

    task automatic t_queue;
        cfg(32'h10f);
        fab.go(0, 0, 0, 0, 9'h0aa);
        fab.go(0, 0, 0, 0, 9'h055);
        ahb(1'b0, STATUS_OFFSET, 0);
        chk(r, 32'h00020008);
        chk(fl, 4'h8);
        fab.go(1, 0, 1, 0, 0);
        #1 chk(rd[1], 9'h0aa);
        $display("queue done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop;
        end
    end

    initial begin
        repeat (16) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        t_regs;
        t_lanes;
        t_pipe_mode;
        t_hold;
        t_queue;
        report_and_stop;
    end
endmodule
`default_nettype wire
